// *** rtl/cfis_pkg.sv ***
// Package with data map, flag layout, vectors and instruction codes of the core control block.
package cfis_pkg;
  localparam int          PC_W         = 13;
  localparam int          STACK_DEPTH  = 8;
  localparam logic [7:0]  ADDR_IND0    = 8'h00;
  localparam logic [7:0]  ADDR_PTR0    = 8'h01;
  localparam logic [7:0]  ADDR_IND1    = 8'h02;
  localparam logic [7:0]  ADDR_PTR1    = 8'h03;
  localparam logic [7:0]  ADDR_WORK    = 8'h05;
  localparam logic [7:0]  ADDR_PCLOW   = 8'h06;
  localparam logic [7:0]  ADDR_FLAG    = 8'h0A;
  localparam logic [7:0]  ADDR_IRQCTL  = 8'h0B;
  localparam logic [7:0]  ADDR_RAM_LO  = 8'h20;
  localparam logic [7:0]  ADDR_RAM_HI  = 8'hFF;
  localparam logic [7:0]  READ_ZERO    = 8'h00;
  localparam int          FLAG_CARRY   = 0;
  localparam int          FLAG_HALF    = 1;
  localparam int          FLAG_NIL     = 2;
  localparam int          FLAG_WRAP    = 3;
  localparam int          FLAG_PDOWN   = 4;
  localparam int          FLAG_WDEXP   = 5;
  localparam logic [7:0]  FLAG_SW_MASK = 8'h0F;
  localparam int          IC_MASTER    = 0;
  localparam int          IC_EXT_EN    = 1;
  localparam int          IC_T0_EN     = 2;
  localparam int          IC_T1_EN     = 3;
  localparam int          IC_EXT_PEND  = 4;
  localparam int          IC_T0_PEND   = 5;
  localparam int          IC_T1_PEND   = 6;
  localparam logic [7:0]  IC_WR_MASK   = 8'h7F;
  localparam logic [12:0] VEC_RESET    = 13'h0000;
  localparam logic [12:0] VEC_EXT      = 13'h0004;
  localparam logic [12:0] VEC_TMR0     = 13'h0008;
  localparam logic [12:0] VEC_TMR1     = 13'h000C;
  typedef enum logic [2:0] {
    CFIS_OP_NONE,
    CFIS_OP_CALL,
    CFIS_OP_SUB_EXIT,
    CFIS_OP_IRQ_EXIT,
    CFIS_OP_WATCHDOG_KICK,
    CFIS_OP_SLEEP
  } cfis_op_t;
  typedef enum logic [2:0] {
    CFIS_ALU_NONE,
    CFIS_ALU_ADD,
    CFIS_ALU_SUB,
    CFIS_ALU_LOGIC,
    CFIS_ALU_ROT
  } cfis_alu_t;
endpackage : cfis_pkg

// *** rtl/cfis_return_stack.sv ***
// Eight-entry return-address stack that keeps the newest entries on overflow.
`timescale 1ns/100ps
`default_nettype none
module cfis_return_stack #(
  parameter int DEPTH = cfis_pkg::STACK_DEPTH,
  parameter int WIDTH = cfis_pkg::PC_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] pushData,
  output logic      [WIDTH-1:0] popData,
  output logic                  full
);
  localparam int IW = $clog2(DEPTH + 1);
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] entry [DEPTH];
  logic [IW-1:0]    returnStackIndex;
  logic [IW-2:0]    topSlot;
  assign topSlot = returnStackIndex[IW-2:0] - 1'b1;
  assign popData = entry[topSlot];
  assign full    = (returnStackIndex == IW'(DEPTH));
  // Index counts occupied entries; zero means empty after reset.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      returnStackIndex <= '0;
    else if (push && !full)
      returnStackIndex <= returnStackIndex + 1'b1;
    else if (pop && !push && returnStackIndex != '0)
      returnStackIndex <= returnStackIndex - 1'b1;
  end
  // A push when full shifts out the oldest entry so the newest eight survive.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_entry
      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
          entry[g] <= '0;
        else if (push && full)
          entry[g] <= (g == DEPTH - 1) ? pushData : entry[(g + 1) % DEPTH];
        else if (push && returnStackIndex[IW-2:0] == (IW-1)'(g))
          entry[g] <= pushData;
      end
    end
  endgenerate
  a_stack_full_push: assert property (@(posedge ref_clk) disable iff (!rstn)
    push && full |=> full && popData == $past(pushData)) else $error("overflow push lost");
endmodule : cfis_return_stack
`default_nettype wire

// *** rtl/cfis_core_ctrl.sv ***
// Core control: return stack, flags, indirect data map and interrupt sequencer.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Eight-entry hidden stack of program counters only
// - Call or interrupt pushes; returns pop
// - Reset leaves the stack empty
// - Full stack holds interrupt pending, not taken
// - Call when full drops the oldest entry
// - Unused locations below 20H read zero
// - General storage spans 20H to FFH
// - Addresses 00H, 02H go through pointers
// - Pointer at indirect port: read zero, no write
// - Carry from add, no-borrow, rotate
// - Half carry from low-nibble carry
// - Nil flag when result is zero
// - Signed wrap when bit-7 carries differ
// - Power-down set by sleep, cleared by kick
// - Watchdog flag set on time-out, cleared by sleep or kick
// - Software writes cannot touch bits 4 and 5
// - Flags are never stacked automatically
// - Acknowledge clears the master enable
// - Falling external pin sets pending, vector 04H
// - Timer 0 overflow pending, vector 08H
// - Timer 1 overflow pending, vector 0CH
// - Timer 1 acknowledge clears its pending, master
// - Priority external, timer 0, timer 1
// - Interrupt return sets master; plain return does not
// - Control bits 0..3 enables; bit 7 zero
module cfis_core_ctrl #(
  parameter int PC_W = cfis_pkg::PC_W
) (
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic [7:0]          regAddr,
  input  wire logic [7:0]          regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [7:0]          regRdata,
  input  wire cfis_pkg::cfis_op_t  instrOp,
  input  wire logic [PC_W-1:0]     callTarget,
  input  wire logic [PC_W-1:0]     currentPc,
  input  wire cfis_pkg::cfis_alu_t aluOp,
  input  wire logic [7:0]          aluA,
  input  wire logic [7:0]          aluB,
  input  wire logic [7:0]          aluResult,
  input  wire logic                carryIn,
  input  wire logic                rotCarryOut,
  input  wire logic                watchdogTimeout,
  input  wire logic                tmr0Overflow,
  input  wire logic                tmr1Overflow,
  input  wire logic                extIrqPin_n,
  output logic                     pcLoad,
  output logic      [PC_W-1:0]     pcTarget,
  output logic                     irqAck,
  output logic      [7:0]          flagOut
);
  initial
  begin
    if (PC_W < 8 || PC_W > cfis_pkg::PC_W) $error("PC_W out of range");
  end

  // Storage: only 20H..FFH is backed by cells.
  logic [7:0] ram [224];
  logic [7:0] pointer0;
  logic [7:0] pointer1;
  logic [7:0] workingReg;
  logic [7:0] flagReg;
  logic       masterIrqEnable;
  logic       extIrqEnable, tmr0IrqEnable, tmr1IrqEnable;
  logic       extIrqPending, tmr0IrqPending, tmr1IrqPending;
  logic       pinSync1, pinSync2, pinPrev;

  // Indirect resolution for the software port.
  logic [7:0] effAddr;
  logic       effBlocked;
  always_comb
  begin
    effAddr    = regAddr;
    effBlocked = 1'b0;
    if (regAddr == cfis_pkg::ADDR_IND0)
      effAddr = pointer0;
    else if (regAddr == cfis_pkg::ADDR_IND1)
      effAddr = pointer1;
    if ((regAddr == cfis_pkg::ADDR_IND0 || regAddr == cfis_pkg::ADDR_IND1)
        && (effAddr == cfis_pkg::ADDR_IND0 || effAddr == cfis_pkg::ADDR_IND1))
      effBlocked = 1'b1;
  end
  logic wrEff;
  assign wrEff = regWr && !effBlocked;

  // Pin passes two flops; the edge detector compares the second with its delayed copy.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      {pinSync1, pinSync2, pinPrev} <= 3'b111;
    else
      {pinSync1, pinSync2, pinPrev} <= {extIrqPin_n, pinSync1, pinSync2};
  end
  logic extFall;
  assign extFall = pinPrev && !pinSync2;

  // Return stack.
  logic [PC_W-1:0] stackTop;
  logic            stackFull, takeIrq, doCall, doReturn;
  assign doCall   = instrOp == cfis_pkg::CFIS_OP_CALL;
  assign doReturn = instrOp == cfis_pkg::CFIS_OP_SUB_EXIT
                 || instrOp == cfis_pkg::CFIS_OP_IRQ_EXIT;
  // Only the program counter goes on the stack; flags stay put.
  cfis_return_stack #(
    .DEPTH (cfis_pkg::STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .push     (doCall || takeIrq),
    .pop      (doReturn),
    .pushData (currentPc),
    .popData  (stackTop),
    .full     (stackFull)
  );

  // Interrupt arbitration; a return in flight frees a slot first, so no take that cycle.
  logic extReady, t0Ready, t1Ready;
  assign extReady = extIrqPending && extIrqEnable;
  assign t0Ready  = tmr0IrqPending && tmr0IrqEnable;
  assign t1Ready  = tmr1IrqPending && tmr1IrqEnable;
  // Calls and returns own the stack in their cycle; the interrupt waits for a cycle with neither.
  assign takeIrq = masterIrqEnable && !stackFull && !doCall && !doReturn
                && (extReady || t0Ready || t1Ready);
  logic takeExt, takeT0, takeT1;
  assign takeExt = takeIrq && extReady;
  assign takeT0  = takeIrq && !extReady && t0Ready;
  assign takeT1  = takeIrq && !extReady && !t0Ready && t1Ready;

  // Program counter redirection outputs.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pcLoad   <= 1'b0;
      pcTarget <= cfis_pkg::VEC_RESET[PC_W-1:0];
      irqAck   <= 1'b0;
    end
    else
    begin
      pcLoad <= takeIrq || doCall || doReturn;
      irqAck <= takeIrq;
      if (takeExt)
        pcTarget <= cfis_pkg::VEC_EXT[PC_W-1:0];
      else if (takeT0)
        pcTarget <= cfis_pkg::VEC_TMR0[PC_W-1:0];
      else if (takeT1)
        pcTarget <= cfis_pkg::VEC_TMR1[PC_W-1:0];
      else if (doCall)
        pcTarget <= callTarget;
      else if (doReturn)
        pcTarget <= stackTop;
    end
  end

  // Interrupt control register: enables, master and sticky pending flags.
  logic icWr;
  assign icWr = wrEff && effAddr == cfis_pkg::ADDR_IRQCTL;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      {tmr1IrqEnable, tmr0IrqEnable, extIrqEnable} <= 3'b000;
    else if (icWr)
      {tmr1IrqEnable, tmr0IrqEnable, extIrqEnable}
        <= {regWdata[cfis_pkg::IC_T1_EN], regWdata[cfis_pkg::IC_T0_EN],
            regWdata[cfis_pkg::IC_EXT_EN]};
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      masterIrqEnable <= 1'b0;
    else if (takeIrq)
      masterIrqEnable <= 1'b0;
    else if (instrOp == cfis_pkg::CFIS_OP_IRQ_EXIT)
      masterIrqEnable <= 1'b1;
    else if (icWr)
      masterIrqEnable <= regWdata[cfis_pkg::IC_MASTER];
  end
  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      {extIrqPending, tmr0IrqPending, tmr1IrqPending} <= 3'b000;
    else
    begin
      if (extFall)
        extIrqPending <= 1'b1;
      else if (takeExt)
        extIrqPending <= 1'b0;
      else if (icWr)
        extIrqPending <= regWdata[cfis_pkg::IC_EXT_PEND];
      if (tmr0Overflow)
        tmr0IrqPending <= 1'b1;
      else if (takeT0)
        tmr0IrqPending <= 1'b0;
      else if (icWr)
        tmr0IrqPending <= regWdata[cfis_pkg::IC_T0_PEND];
      if (tmr1Overflow)
        tmr1IrqPending <= 1'b1;
      else if (takeT1)
        tmr1IrqPending <= 1'b0;
      else if (icWr)
        tmr1IrqPending <= regWdata[cfis_pkg::IC_T1_PEND];
    end
  end

  // Flags from the ALU.
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic [7:0] bOp;
  logic       isArith;
  always_comb
  begin
    bOp     = (aluOp == cfis_pkg::CFIS_ALU_SUB) ? ~aluB : aluB;
    sum9    = {1'b0, aluA} + {1'b0, bOp} + {8'h00, carryIn};
    sum5    = {1'b0, aluA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, carryIn};
    sum7    = {1'b0, aluA[6:0]} + {1'b0, bOp[6:0]} + {7'h00, carryIn};
    isArith = aluOp == cfis_pkg::CFIS_ALU_ADD || aluOp == cfis_pkg::CFIS_ALU_SUB;
  end
  logic flagWr;
  assign flagWr = wrEff && effAddr == cfis_pkg::ADDR_FLAG;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      flagReg[3:0] <= 4'h0;
    else if (flagWr)
      flagReg[3:0] <= regWdata[3:0] & cfis_pkg::FLAG_SW_MASK[3:0];
    else
    begin
      if (isArith)
      begin
        // Subtraction uses A + ~B + carry, so carry out means no borrow.
        flagReg[cfis_pkg::FLAG_CARRY] <= sum9[8];
        flagReg[cfis_pkg::FLAG_HALF]  <= sum5[4];
        flagReg[cfis_pkg::FLAG_WRAP]  <= sum7[7] ^ sum9[8];
      end
      else if (aluOp == cfis_pkg::CFIS_ALU_ROT)
        flagReg[cfis_pkg::FLAG_CARRY] <= rotCarryOut;
      if (isArith || aluOp == cfis_pkg::CFIS_ALU_LOGIC)
        flagReg[cfis_pkg::FLAG_NIL] <= aluResult == 8'h00;
    end
  end
  // Power-down and watchdog flags ignore software writes.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      flagReg[7:4] <= 4'h0;
    else
    begin
      if (instrOp == cfis_pkg::CFIS_OP_SLEEP)
        flagReg[cfis_pkg::FLAG_PDOWN] <= 1'b1;
      else if (instrOp == cfis_pkg::CFIS_OP_WATCHDOG_KICK)
        flagReg[cfis_pkg::FLAG_PDOWN] <= 1'b0;
      // A time-out in the same cycle as a clear is kept.
      if (watchdogTimeout)
        flagReg[cfis_pkg::FLAG_WDEXP] <= 1'b1;
      else if (instrOp == cfis_pkg::CFIS_OP_SLEEP
               || instrOp == cfis_pkg::CFIS_OP_WATCHDOG_KICK)
        flagReg[cfis_pkg::FLAG_WDEXP] <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      flagOut <= 8'h00;
    else
      flagOut <= {2'b00, flagReg[5:0]};
  end

  // Plain registers and general storage.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      {pointer0, pointer1, workingReg} <= 24'h000000;
    else if (wrEff)
    begin
      if (effAddr == cfis_pkg::ADDR_PTR0)
        pointer0 <= regWdata;
      if (effAddr == cfis_pkg::ADDR_PTR1)
        pointer1 <= regWdata;
      if (effAddr == cfis_pkg::ADDR_WORK)
        workingReg <= regWdata;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 224; gi++)
    begin : g_ram
      always_ff @(posedge ref_clk)
      begin
        if (wrEff && effAddr == 8'(gi + 32))
          ram[gi] <= regWdata;
      end
    end
  endgenerate

  // Read path: one cycle later; unmapped and blocked reads give zero.
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = cfis_pkg::READ_ZERO;
    if (effBlocked)
      next_rdata = cfis_pkg::READ_ZERO;
    else if (effAddr >= cfis_pkg::ADDR_RAM_LO)
      next_rdata = ram[effAddr - cfis_pkg::ADDR_RAM_LO];
    else
      unique case (effAddr)
        cfis_pkg::ADDR_PTR0:   next_rdata = pointer0;
        cfis_pkg::ADDR_PTR1:   next_rdata = pointer1;
        cfis_pkg::ADDR_WORK:   next_rdata = workingReg;
        cfis_pkg::ADDR_PCLOW:  next_rdata = currentPc[7:0];
        cfis_pkg::ADDR_FLAG:   next_rdata = {2'b00, flagReg[5:0]};
        cfis_pkg::ADDR_IRQCTL: next_rdata = {1'b0, tmr1IrqPending, tmr0IrqPending,
                                            extIrqPending, tmr1IrqEnable, tmr0IrqEnable,
                                            extIrqEnable, masterIrqEnable};
        default:               next_rdata = cfis_pkg::READ_ZERO;
      endcase
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      regRdata <= 8'h00;
    else if (regRd)
      regRdata <= next_rdata;
    else
      regRdata <= 8'h00;
  end

  a_ack_clears_master: assert property (@(posedge ref_clk) disable iff (!rstn)
    takeIrq |=> !masterIrqEnable && irqAck) else $error("ack kept master on");
  a_full_blocks_ack: assert property (@(posedge ref_clk) disable iff (!rstn)
    stackFull |=> !irqAck) else $error("ack with full stack");
  a_ext_vector: assert property (@(posedge ref_clk) disable iff (!rstn)
    takeExt && !extFall |=> pcTarget == cfis_pkg::VEC_EXT[PC_W-1:0] && !extIrqPending)
    else $error("external vector wrong");
  a_t0_priority: assert property (@(posedge ref_clk) disable iff (!rstn)
    takeIrq && t0Ready && !extReady
    |=> irqAck && pcTarget == cfis_pkg::VEC_TMR0[PC_W-1:0])
    else $error("timer 0 order wrong");
  a_t1_vector: assert property (@(posedge ref_clk) disable iff (!rstn)
    takeT1 && !tmr1Overflow |=> pcTarget == cfis_pkg::VEC_TMR1[PC_W-1:0] && !tmr1IrqPending)
    else $error("timer 1 vector wrong");
  a_irq_exit_master: assert property (@(posedge ref_clk) disable iff (!rstn)
    instrOp == cfis_pkg::CFIS_OP_IRQ_EXIT |=> masterIrqEnable)
    else $error("irq exit left master off");
  a_flag_sw_safe: assert property (@(posedge ref_clk) disable iff (!rstn)
    flagWr && instrOp == cfis_pkg::CFIS_OP_NONE && !watchdogTimeout
    |=> flagReg[5:4] == $past(flagReg[5:4])) else $error("write hit protected flags");
  a_sleep_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
    instrOp == cfis_pkg::CFIS_OP_SLEEP && !watchdogTimeout
    |=> ##1 flagOut[5:4] == 2'b01) else $error("sleep flags wrong");
  a_ind_blocked_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    regRd && effBlocked |=> regRdata == 8'h00) else $error("self indirect read nonzero");
  a_pending_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
    extIrqPending && !takeExt && !icWr |=> extIrqPending) else $error("pending lost");
endmodule : cfis_core_ctrl
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the core control block: data map, flags, return stack, interrupts.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                ref_clk;
  logic                rstn;
  logic [7:0]          regAddr;
  logic [7:0]          regWdata;
  logic                regWr;
  logic                regRd;
  logic [7:0]          regRdata;
  cfis_pkg::cfis_op_t  instrOp;
  logic [12:0]         callTarget;
  logic [12:0]         currentPc;
  cfis_pkg::cfis_alu_t aluOp;
  logic [7:0]          aluA;
  logic [7:0]          aluB;
  logic [7:0]          aluResult;
  logic                carryIn;
  logic                rotCarryOut;
  logic                watchdogTimeout;
  logic                tmr0Overflow;
  logic                tmr1Overflow;
  logic                extIrqPin_n;
  logic                pcLoad;
  logic [12:0]         pcTarget;
  logic                irqAck;
  logic [7:0]          flagOut;
  cfis_pkg::cfis_alu_t aOp;
  logic [7:0]          aA, aB, aR, expFlag, nt8;
  logic                aC, aRot, pinN, rdSeen, flagRd;
  logic [12:0]         tgt, curPc;
  logic [15:0]         rdQ[$];
  logic [13:0]         pcQ[$];
  logic [15:0]         nt;
  logic [13:0]         pn;
  logic [7:0]          ramA[5];
  logic [7:0]          ramD[5];
  int                  err_total, checks, cycles;

  cfis_core_ctrl u_dut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .instrOp(instrOp), .callTarget(callTarget), .currentPc(currentPc), .aluOp(aluOp),
    .aluA(aluA), .aluB(aluB), .aluResult(aluResult), .carryIn(carryIn),
    .rotCarryOut(rotCarryOut), .watchdogTimeout(watchdogTimeout),
    .tmr0Overflow(tmr0Overflow), .tmr1Overflow(tmr1Overflow), .extIrqPin_n(extIrqPin_n),
    .pcLoad(pcLoad), .pcTarget(pcTarget), .irqAck(irqAck), .flagOut(flagOut));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Every driven input is assigned exactly once per cycle, so back-to-back calls never race.
  task automatic step(input cfis_pkg::cfis_op_t op, input logic w, input logic r,
                      input logic [7:0] a, input logic [7:0] d, input logic [2:0] ev);
    instrOp <= op;
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWdata <= d;
    {watchdogTimeout, tmr1Overflow, tmr0Overflow} <= ev;
    aluOp <= aOp;
    aluA <= aA;
    aluB <= aB;
    aluResult <= aR;
    carryIn <= aC;
    rotCarryOut <= aRot;
    extIrqPin_n <= pinN;
    callTarget <= tgt;
    currentPc <= curPc;
    aOp = cfis_pkg::CFIS_ALU_NONE;
    @(posedge ref_clk);
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(cfis_pkg::CFIS_OP_NONE, 1'b1, 1'b0, a, d, 3'b000);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    rdQ.push_back({m, e & m});
    step(cfis_pkg::CFIS_OP_NONE, 1'b0, 1'b1, a, 8'h00, 3'b000);
  endtask : rdc

  task automatic op(input cfis_pkg::cfis_op_t o, input logic [2:0] ev = 3'b000);
    step(o, 1'b0, 1'b0, 8'h00, 8'h00, ev);
  endtask : op

  task automatic idle(input int n);
    repeat (n) op(cfis_pkg::CFIS_OP_NONE);
  endtask : idle

  task automatic expPc(input logic irq, input logic [12:0] v);
    pcQ.push_back({irq, v});
  endtask : expPc

  // Result and arithmetic flags are worked out here from the operands alone.
  task automatic alu(input cfis_pkg::cfis_alu_t o, input logic [7:0] a, input logic [7:0] b,
                     input logic ci, input logic ro);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] lo;
    logic [7:0] lo7;
    bb = (o == cfis_pkg::CFIS_ALU_SUB) ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    lo7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
    aOp = o;
    aA = a;
    aB = b;
    aC = ci;
    aRot = ro;
    aR = (o == cfis_pkg::CFIS_ALU_LOGIC) ? (a & b) : s[7:0];
    if (o == cfis_pkg::CFIS_ALU_LOGIC)
      expFlag[2] = (aR == 8'h00);
    else if (o == cfis_pkg::CFIS_ALU_ROT)
      expFlag[0] = ro;
    else
      expFlag[3:0] = {lo7[7] ^ s[8], s[7:0] == 8'h00, lo[4], s[8]};
    op(cfis_pkg::CFIS_OP_NONE);
  endtask : alu

  always @(posedge ref_clk)
  begin
    rdSeen <= regRd;
    flagRd <= regRd && regAddr == cfis_pkg::ADDR_FLAG;
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      end_sim();
    end
  end

  // Read data stand only in the cycle after the strobe; pcLoad marks each program-counter load.
  always @(negedge ref_clk)
  begin
    if (rdSeen === 1'b1)
    begin
      nt = (rdQ.size() > 0) ? rdQ.pop_front() : 16'hFFFF;
      nt8 = regRdata & nt[15:8];
      chk("regRdata", {8'h00, nt[7:0]}, {8'h00, nt8});
      if (flagRd === 1'b1)
        chk("flagOut", {8'h00, nt[7:0]}, {8'h00, flagOut & nt[15:8]});
    end
    if (pcLoad !== 1'b0)
    begin
      pn = (pcQ.size() > 0) ? pcQ.pop_front() : 14'h3FFF;
      chk("pcTarget", {2'b00, pn}, {2'b00, irqAck, pcTarget});
    end
  end

  initial
  begin
    {regAddr, regWdata, aA, aB, aR, expFlag} = '0;
    {regWr, regRd, aC, aRot, rdSeen, flagRd, carryIn, rotCarryOut} = '0;
    {watchdogTimeout, tmr0Overflow, tmr1Overflow, aluA, aluB, aluResult} = '0;
    {callTarget, currentPc, tgt, curPc} = '0;
    {err_total, checks, cycles} = '0;
    instrOp = cfis_pkg::CFIS_OP_NONE;
    aluOp = cfis_pkg::CFIS_ALU_NONE;
    aOp = cfis_pkg::CFIS_ALU_NONE;
    pinN = 1'b1;
    extIrqPin_n = 1'b1;
    rstn = 1'b0;
    void'($urandom(32'h9e7fa30b));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(cfis_pkg::ADDR_FLAG, 8'h00);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h00);
    ramA = '{8'h20, 8'hFF, 8'h21 + 8'($urandom_range(0, 94)), 8'h80, 8'hFE};
    foreach (ramA[i]) ramD[i] = 8'($urandom());
    foreach (ramA[i]) wr(ramA[i], ramD[i]);
    foreach (ramA[i]) rdc(ramA[i], ramD[i]);
    foreach (ramA[i]) wr(8'h04 + 8'(i * 5), 8'hFF);
    foreach (ramA[i]) rdc(8'h04 + 8'(i * 5), 8'h00);
    wr(cfis_pkg::ADDR_WORK, ramD[0]);
    rdc(cfis_pkg::ADDR_WORK, ramD[0]);
    wr(cfis_pkg::ADDR_PTR0, 8'h40);
    wr(cfis_pkg::ADDR_IND0, 8'hA5);
    rdc(8'h40, 8'hA5);
    wr(cfis_pkg::ADDR_PTR1, 8'hFE);
    wr(8'hFE, 8'h5A);
    rdc(cfis_pkg::ADDR_IND1, 8'h5A);
    wr(cfis_pkg::ADDR_PTR0, cfis_pkg::ADDR_IND1);
    wr(cfis_pkg::ADDR_IND0, 8'h33);
    rdc(cfis_pkg::ADDR_IND0, 8'h00);
    rdc(8'hFE, 8'h5A);
    alu(cfis_pkg::CFIS_ALU_ADD, 8'h7F, 8'h01, 1'b0, 1'b0);
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    alu(cfis_pkg::CFIS_ALU_ADD, 8'hFF, 8'h01, 1'b0, 1'b0);
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    alu(cfis_pkg::CFIS_ALU_SUB, 8'h80, 8'h01, 1'b1, 1'b0);
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    repeat (6)
    begin
      aA = 8'($urandom());
      alu($urandom_range(0, 1) ? cfis_pkg::CFIS_ALU_SUB : cfis_pkg::CFIS_ALU_ADD,
          aA, 8'($urandom()), 1'($urandom_range(0, 1)), 1'b0);
      rdc(cfis_pkg::ADDR_FLAG, expFlag);
    end
    alu(cfis_pkg::CFIS_ALU_LOGIC, 8'hF0, 8'h0F, 1'b0, 1'b0);
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    alu(cfis_pkg::CFIS_ALU_ROT, 8'h81, 8'h00, 1'b0, ~expFlag[0]);
    rdc(cfis_pkg::ADDR_FLAG, expFlag, 8'h01);
    alu(cfis_pkg::CFIS_ALU_ADD, 8'h08, 8'h08, 1'b0, 1'b0);
    op(cfis_pkg::CFIS_OP_NONE, 3'b100);
    expFlag[5] = 1'b1;
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    op(cfis_pkg::CFIS_OP_SLEEP);
    expFlag[5:4] = 2'b01;
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    op(cfis_pkg::CFIS_OP_NONE, 3'b100);
    wr(cfis_pkg::ADDR_FLAG, 8'hC0);
    expFlag = 8'h30;
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    op(cfis_pkg::CFIS_OP_WATCHDOG_KICK);
    expFlag[5:4] = 2'b00;
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    for (int i = 0; i < 9; i++)
    begin
      tgt = 13'h0100 + 13'(i);
      curPc = 13'h0200 + 13'(i);
      expPc(1'b0, tgt);
      op(cfis_pkg::CFIS_OP_CALL);
    end
    curPc = 13'h0A55;
    rdc(cfis_pkg::ADDR_PCLOW, 8'h55);
    wr(cfis_pkg::ADDR_IRQCTL, 8'h05);
    op(cfis_pkg::CFIS_OP_NONE, 3'b001);
    idle(6);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h25);
    expPc(1'b0, 13'h0208);
    expPc(1'b1, cfis_pkg::VEC_TMR0);
    op(cfis_pkg::CFIS_OP_SUB_EXIT);
    idle(4);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h04);
    expPc(1'b0, 13'h0A55);
    op(cfis_pkg::CFIS_OP_IRQ_EXIT);
    idle(2);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h05);
    for (int i = 7; i > 0; i--)
    begin
      expPc(1'b0, 13'h0200 + 13'(i));
      op(cfis_pkg::CFIS_OP_SUB_EXIT);
    end
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h05);
    wr(cfis_pkg::ADDR_IRQCTL, 8'h00);
    pinN = 1'b0;
    op(cfis_pkg::CFIS_OP_NONE, 3'b011);
    idle(5);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h70);
    expPc(1'b1, cfis_pkg::VEC_EXT);
    wr(cfis_pkg::ADDR_IRQCTL, 8'h7F);
    idle(4);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h6E);
    expPc(1'b0, 13'h0A55);
    expPc(1'b1, cfis_pkg::VEC_TMR0);
    op(cfis_pkg::CFIS_OP_IRQ_EXIT);
    idle(4);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h4E);
    expPc(1'b0, 13'h0A55);
    expPc(1'b1, cfis_pkg::VEC_TMR1);
    op(cfis_pkg::CFIS_OP_IRQ_EXIT);
    idle(4);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h0E);
    rdc(cfis_pkg::ADDR_FLAG, expFlag);
    op(cfis_pkg::CFIS_OP_NONE, 3'b001);
    idle(3);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h2E);
    wr(cfis_pkg::ADDR_IRQCTL, 8'h0E);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h0E);
    expPc(1'b0, 13'h0A55);
    op(cfis_pkg::CFIS_OP_IRQ_EXIT);
    idle(3);
    rdc(cfis_pkg::ADDR_IRQCTL, 8'h0F);
    idle(3);
    chk("queues", 16'h0000, 16'(rdQ.size() + pcQ.size()));
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
